// File: hw/opa_pkg.sv
// package: register indices, field positions, reset values and timing for the protection front end
package opa_pkg;
    // register indices; the byte address is four times the index
    localparam logic [15:0] IDX_AMP_ENABLE = 16'h404e;
    localparam logic [15:0] IDX_AMP_GAIN = 16'h40f2;
    localparam logic [15:0] IDX_GROUND_TEMP = 16'h40f3;
    localparam logic [15:0] IDX_EVENT_FILTER = 16'h4100;
    localparam logic [15:0] IDX_CMP_CTRL_0 = 16'h4101;
    localparam logic [15:0] IDX_CMP_CTRL_1 = 16'h4102;
    localparam logic [15:0] IDX_DRIVER_OUT = 16'h4103;
    localparam int ADDR_SHIFT = 2;

    // amplifier_enable_control fields
    localparam int AMP_BUS_EN_BIT = 0;
    localparam int AMP_PHA_EN_BIT = 1;
    localparam int AMP_PHB_EN_BIT = 2;
    localparam logic [2:0] AMP_ENABLE_RST = 3'h0;

    // amplifier_gain_control fields
    localparam int GAIN_ROUTE_BIT = 0;
    localparam int GAIN_BUS_LSB = 1;
    localparam int GAIN_PHASE_LSB = 4;
    localparam int GAIN_DAC_LSB_BIT = 7;
    localparam logic [7:0] AMP_GAIN_RST = 8'h00;

    // ground_switch_temp_adjust fields
    localparam int TEMP_BOTTOM_BIT = 0;
    localparam int TEMP_TOP_BIT = 1;
    localparam int BUS_GND_BIT = 2;
    localparam int PHASE_GND_BIT = 3;
    localparam logic [3:0] GROUND_TEMP_RST = 4'h0;

    // event_filter_reg fields
    localparam int EVF_MODE_LSB = 0;
    localparam int EVF_SRC_BIT = 2;
    localparam int EVF_WIDTH_LSB = 3;
    localparam int EVF_TEMP_LSB = 5;
    localparam logic [6:0] EVENT_FILTER_RST = 7'h00;

    // comparator_ctrl_0 fields
    localparam int CC0_IRQ_MODE_LSB = 0;
    localparam int CC0_EDGE_SEL_BIT = 2;
    localparam logic [2:0] CMP_CTRL_0_RST = 3'h0;

    // comparator_ctrl_1 fields
    localparam int CC1_MODE_LSB = 0;
    localparam int CC1_HYST_BIT = 2;
    localparam int CC1_ENABLE_BIT = 3;
    localparam logic [3:0] CMP_CTRL_1_RST = 4'h0;

    // driver_output_reg fields
    localparam int DRV_MOE_BIT = 0;
    localparam int DRV_FLAG_BIT = 1;
    localparam int DRV_CMP_OUT_BIT = 2;
    localparam logic MOE_RST = 1'b0;

    // encodings
    localparam logic [1:0] PROT_MODE_NOTIFY = 2'b00;
    localparam logic [1:0] PROT_MODE_SHUTDOWN = 2'b01;
    localparam logic [1:0] CMP_IRQ_PROTECT = 2'b11;
    localparam logic [1:0] CMP_MODE_SINGLE = 2'b00;
    localparam logic [1:0] CMP_MODE_DUAL = 2'b01;
    localparam logic [2:0] GAIN_RESERVED = 3'b101;
    localparam logic [3:0] TEMP_RESERVED = 4'b0111;

    // glitch filter widths in system clock cycles
    localparam logic [4:0] FILT_WIDTH_1 = 5'd4;
    localparam logic [4:0] FILT_WIDTH_2 = 5'd8;
    localparam logic [4:0] FILT_WIDTH_3 = 5'd16;

    // pin synchroniser depth
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        OPA_GAIN_EXTERNAL,
        OPA_GAIN_INTERNAL,
        OPA_GAIN_RESERVED
    } opa_gain_kind_t;
endpackage

// File: hw/opa_glitch_filter.sv
// glitch filter: output follows the input once it has held steady for the selected width
module opa_glitch_filter
    import opa_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic sig_in,
    input wire logic [1:0] width_sel,
    output logic sig_out
);
    logic [4:0] cnt;
    logic [4:0] limit;

    // width decode, code 0 bypasses the filter
    assign limit = (width_sel == 2'b01) ? FILT_WIDTH_1 :
                   (width_sel == 2'b10) ? FILT_WIDTH_2 : FILT_WIDTH_3;

    // count cycles of disagreement; a short pulse resets the count and never reaches the output
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cnt <= 5'h00;
            sig_out <= 1'b0;
        end
        else if (width_sel == 2'b00)
        begin
            cnt <= 5'h00;
            sig_out <= sig_in;
        end
        else if (sig_in == sig_out)
            cnt <= 5'h00;
        else if (cnt == limit - 5'd1)
        begin
            cnt <= 5'h00;
            sig_out <= sig_in; // [R17] [R18]
        end
        else
            cnt <= cnt + 5'd1;
    end
endmodule

// File: hw/opa_ctrl.sv
// overcurrent protection and analog front-end control with an AHB-Lite register slave
// Behaviour
// [R01] three amplifier enable bits, reset zero
// [R02] phase gain code maps 2X to 16X
// [R03] bus gain code uses same mapping
// [R04] gain bit seven holds converter LSB
// [R05] gain bit zero routes comparator to pin
// [R06] phase ground bit grounds inputs, lowers midpoint
// [R07] bus ground bit grounds bus input
// [R08] temperature code assembled from two registers
// [R09] temperature code order, 0111 reserved
// [R10] comparator mode single, dual or triple
// [R11] software enables comparator last
// [R12] protection event in mode 01 clears main output enable
// [R13] mode 01 clears enable and flags
// [R14] mode 00 only flags, keeps enable
// [R15] source one takes external line edge
// [R16] source zero takes comparator rising edge
// [R17] filter width 4, 8 or 16
// [R18] filtered signal lags by width, plus one
// [R19] comparator high sets flag, goes filtered
// [R20] triple any phase, single bus current
// [R21] software sets analog pins before enabling
// [R22] cleared enable and flag stay until software
module opa_ctrl
    import opa_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [2:0] current_comparator,
    input wire logic external_interrupt_line,
    output logic bus_amp_enable,
    output logic phase_a_amp_enable,
    output logic phase_b_amp_enable,
    output logic [2:0] phase_gain_sel,
    output logic [2:0] bus_gain_sel,
    output opa_gain_kind_t phase_gain_kind,
    output logic [1:0] phase_gain_log2,
    output opa_gain_kind_t bus_gain_kind,
    output logic [1:0] bus_gain_log2,
    output logic dac_data_lsb,
    output logic shared_pin_route_en,
    output logic phase_neg_ground_en,
    output logic bus_neg_ground_en,
    output logic phase_midpoint_reduced,
    output logic bus_midpoint_reduced,
    output logic [3:0] temp_code,
    output logic temp_code_valid,
    output logic [1:0] current_comparator_mode,
    output logic current_comparator_hyst,
    output logic current_comparator_enable,
    output logic current_comparator_out_flag,
    output logic main_output_enable,
    output logic protection_irq
);
    import opa_pkg::*;

    // software-held state
    logic [2:0] amp_enable_q;
    logic [7:0] amp_gain_q;
    logic [3:0] ground_temp_q;
    logic [6:0] event_filter_q;
    logic [2:0] cmp_ctrl_0_q;
    logic [3:0] cmp_ctrl_1_q;
    logic moe_q;
    logic prot_flag_q;

    // bus phase tracking
    logic wr_pending;
    logic rd_pending;
    logic [15:0] dp_index;

    // input conditioning
    logic [3:0] sync_1;
    logic [3:0] sync_2;
    logic [3:0] sync_3;
    logic [3:0] clean;
    logic filtered;
    logic filtered_d;

    // address phase decode
    wire logic addr_take = hsel && htrans[1] && hready;
    wire logic [15:0] ap_index = haddr[ADDR_SHIFT +: 16];
    wire logic in_range = (haddr[31:ADDR_SHIFT + 16] == '0) && (haddr[ADDR_SHIFT - 1:0] == '0);

    // data phase write strobes, unmapped indices fall through and are ignored
    wire logic wr_amp_en = wr_pending && (dp_index == IDX_AMP_ENABLE);
    wire logic wr_amp_gain = wr_pending && (dp_index == IDX_AMP_GAIN);
    wire logic wr_gnd_temp = wr_pending && (dp_index == IDX_GROUND_TEMP);
    wire logic wr_evf = wr_pending && (dp_index == IDX_EVENT_FILTER);
    wire logic wr_cc0 = wr_pending && (dp_index == IDX_CMP_CTRL_0);
    wire logic wr_cc1 = wr_pending && (dp_index == IDX_CMP_CTRL_1);
    wire logic wr_drv = wr_pending && (dp_index == IDX_DRIVER_OUT);

    // comparator channel and event filter fields
    wire logic [1:0] cmp_mode = cmp_ctrl_1_q[CC1_MODE_LSB +: 2];
    wire logic cmp_en = cmp_ctrl_1_q[CC1_ENABLE_BIT];
    wire logic [1:0] cmp_irq_mode = cmp_ctrl_0_q[CC0_IRQ_MODE_LSB +: 2];
    wire logic edge_falling = cmp_ctrl_0_q[CC0_EDGE_SEL_BIT];
    wire logic [1:0] prot_mode = event_filter_q[EVF_MODE_LSB +: 2];
    wire logic prot_src = event_filter_q[EVF_SRC_BIT];
    wire logic [1:0] filt_width = event_filter_q[EVF_WIDTH_LSB +: 2];

    // comparator output combined by channel mode; a disabled comparator reads low
    wire logic cmp_level = !cmp_en ? 1'b0 :
                           (cmp_mode == CMP_MODE_SINGLE) ? clean[0] : // [R20]
                           (cmp_mode == CMP_MODE_DUAL) ? (clean[0] || clean[1]) : // [R10]
                           (|clean[2:0]); // [R20]
    wire logic ext_level = edge_falling ? !clean[3] : clean[3];

    // pre-filter protection level; the comparator path only counts in protect irq mode
    wire logic prot_level = prot_src ? ext_level : // [R15]
                            ((cmp_irq_mode == CMP_IRQ_PROTECT) && cmp_level); // [R16] [R19]
    wire logic prot_event = filtered && !filtered_d; // [R16]
    wire logic auto_off = prot_event && (prot_mode == PROT_MODE_SHUTDOWN); // [R13]

    // gain decode, shared by both amplifier fields
    wire logic [2:0] ph_code = amp_gain_q[GAIN_PHASE_LSB +: 3];
    wire logic [2:0] bus_code = amp_gain_q[GAIN_BUS_LSB +: 3];
    wire logic ph_internal = (ph_code >= 3'b001) && (ph_code <= 3'b100);
    wire logic bus_internal = (bus_code >= 3'b001) && (bus_code <= 3'b100);
    wire logic [1:0] ph_log2 = ph_code[1:0] - 2'd1;
    wire logic [1:0] bus_log2 = bus_code[1:0] - 2'd1;
    wire opa_gain_kind_t ph_kind = (ph_code == GAIN_RESERVED) ? OPA_GAIN_RESERVED :
                                   ph_internal ? OPA_GAIN_INTERNAL : OPA_GAIN_EXTERNAL; // [R02]
    wire opa_gain_kind_t bus_kind = (bus_code == GAIN_RESERVED) ? OPA_GAIN_RESERVED :
                                    bus_internal ? OPA_GAIN_INTERNAL : OPA_GAIN_EXTERNAL; // [R03]

    // temperature code: top, two middle bits from the event filter register, bottom
    wire logic [3:0] temp_next = {ground_temp_q[TEMP_TOP_BIT], event_filter_q[EVF_TEMP_LSB +: 2],
                                  ground_temp_q[TEMP_BOTTOM_BIT]}; // [R08]

    // read mux for the register selected in the data phase
    wire logic [31:0] rd_mux =
        (dp_index == IDX_AMP_ENABLE) ? {29'h0, amp_enable_q} :
        (dp_index == IDX_AMP_GAIN) ? {24'h0, amp_gain_q} :
        (dp_index == IDX_GROUND_TEMP) ? {28'h0, ground_temp_q} :
        (dp_index == IDX_EVENT_FILTER) ? {25'h0, event_filter_q} :
        (dp_index == IDX_CMP_CTRL_0) ? {29'h0, cmp_ctrl_0_q} :
        (dp_index == IDX_CMP_CTRL_1) ? {28'h0, cmp_ctrl_1_q} :
        (dp_index == IDX_DRIVER_OUT) ? {29'h0, cmp_level, prot_flag_q, moe_q} :
        32'h0000_0000;

    // bus phase capture; reads take one wait state so hrdata comes from a flop
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_pending <= 1'b0;
            rd_pending <= 1'b0;
            dp_index <= 16'h0000;
        end
        else if (hready)
        begin
            wr_pending <= addr_take && hwrite;
            rd_pending <= addr_take && !hwrite;
            dp_index <= in_range ? ap_index : 16'hffff;
        end
        else
            rd_pending <= 1'b0;
    end

    // bus answer; only OKAY is ever given
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hreadyout <= 1'b1;
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= !(addr_take && !hwrite && hready);
            hrdata <= rd_pending ? rd_mux : hrdata;
            hresp <= 1'b0;
        end
    end

    // plain control registers, written in the data phase
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            amp_enable_q <= AMP_ENABLE_RST; // [R01]
            amp_gain_q <= AMP_GAIN_RST;
            ground_temp_q <= GROUND_TEMP_RST;
            event_filter_q <= EVENT_FILTER_RST;
            cmp_ctrl_0_q <= CMP_CTRL_0_RST;
            cmp_ctrl_1_q <= CMP_CTRL_1_RST;
        end
        else
        begin
            if (wr_amp_en)
                amp_enable_q <= hwdata[2:0]; // [R01]
            if (wr_amp_gain)
                amp_gain_q <= hwdata[7:0]; // [R04]
            if (wr_gnd_temp)
                ground_temp_q <= hwdata[3:0];
            if (wr_evf)
                event_filter_q <= hwdata[6:0];
            if (wr_cc0)
                cmp_ctrl_0_q <= hwdata[2:0];
            if (wr_cc1)
                cmp_ctrl_1_q <= hwdata[3:0]; // [R11]
        end
    end

    // main output enable and protection flag; hardware wins over a same-cycle software write
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            moe_q <= MOE_RST;
            prot_flag_q <= 1'b0;
        end
        else
        begin
            if (auto_off)
                moe_q <= 1'b0; // [R12] [R13] [R22]
            else if (wr_drv)
                moe_q <= hwdata[DRV_MOE_BIT]; // [R14]
            if (prot_event)
                prot_flag_q <= 1'b1; // [R13] [R14] [R22]
            else if (wr_drv && hwdata[DRV_FLAG_BIT])
                prot_flag_q <= 1'b0;
        end
    end

    // three-stage pin synchroniser; a change is taken once stages two and three agree
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            sync_1 <= 4'h0;
            sync_2 <= 4'h0;
            sync_3 <= 4'h0;
            clean <= 4'h0;
        end
        else
        begin
            sync_1 <= {external_interrupt_line, current_comparator};
            sync_2 <= sync_1;
            sync_3 <= sync_2;
            clean <= (sync_2 & sync_3) | (clean & (sync_2 | sync_3));
        end
    end

    // glitch filter on the protection level
    opa_glitch_filter u_filter (
        .clock(clock),
        .sys_rst(sys_rst),
        .sig_in(prot_level),
        .width_sel(filt_width), // [R17]
        .sig_out(filtered)
    );

    // edge detection after the filter, so a filtered-out glitch never fires
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            filtered_d <= 1'b0;
        else
            filtered_d <= filtered; // [R18]
    end

    // registered outputs: amplifier controls and routing
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            bus_amp_enable <= 1'b0;
            phase_a_amp_enable <= 1'b0;
            phase_b_amp_enable <= 1'b0;
            phase_gain_sel <= 3'h0;
            bus_gain_sel <= 3'h0;
            phase_gain_kind <= OPA_GAIN_EXTERNAL;
            phase_gain_log2 <= 2'h0;
            bus_gain_kind <= OPA_GAIN_EXTERNAL;
            bus_gain_log2 <= 2'h0;
            dac_data_lsb <= 1'b0;
            shared_pin_route_en <= 1'b0;
        end
        else
        begin
            bus_amp_enable <= amp_enable_q[AMP_BUS_EN_BIT]; // [R01] [R21]
            phase_a_amp_enable <= amp_enable_q[AMP_PHA_EN_BIT];
            phase_b_amp_enable <= amp_enable_q[AMP_PHB_EN_BIT];
            phase_gain_sel <= ph_code;
            bus_gain_sel <= bus_code;
            phase_gain_kind <= ph_kind; // [R02]
            phase_gain_log2 <= ph_internal ? ph_log2 : 2'h0;
            bus_gain_kind <= bus_kind; // [R03]
            bus_gain_log2 <= bus_internal ? bus_log2 : 2'h0;
            dac_data_lsb <= amp_gain_q[GAIN_DAC_LSB_BIT]; // [R04]
            shared_pin_route_en <= amp_gain_q[GAIN_ROUTE_BIT]; // [R05]
        end
    end

    // registered outputs: ground switches, temperature, comparator and protection
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            phase_neg_ground_en <= 1'b0;
            bus_neg_ground_en <= 1'b0;
            phase_midpoint_reduced <= 1'b0;
            bus_midpoint_reduced <= 1'b0;
            temp_code <= 4'h0;
            temp_code_valid <= 1'b1;
            current_comparator_mode <= 2'h0;
            current_comparator_hyst <= 1'b0;
            current_comparator_enable <= 1'b0;
            current_comparator_out_flag <= 1'b0;
            main_output_enable <= 1'b0;
            protection_irq <= 1'b0;
        end
        else
        begin
            phase_neg_ground_en <= ground_temp_q[PHASE_GND_BIT]; // [R06]
            bus_neg_ground_en <= ground_temp_q[BUS_GND_BIT]; // [R07]
            phase_midpoint_reduced <= ground_temp_q[PHASE_GND_BIT]; // [R06]
            bus_midpoint_reduced <= ground_temp_q[BUS_GND_BIT];
            temp_code <= temp_next; // [R08]
            temp_code_valid <= (temp_next != TEMP_RESERVED); // [R09]
            current_comparator_mode <= cmp_mode; // [R10]
            current_comparator_hyst <= cmp_ctrl_1_q[CC1_HYST_BIT];
            current_comparator_enable <= cmp_en;
            current_comparator_out_flag <= cmp_level; // [R19]
            main_output_enable <= moe_q && !auto_off; // [R12]
            protection_irq <= prot_flag_q || prot_event;
        end
    end
endmodule

// File: tb/opa_analog_model.sv
// far-side model: comparators and external pin with a settling delay
module opa_analog_model #(
    parameter int SETTLE_NS = 7
) (
    input wire logic [2:0] over,
    input wire logic ext_drive,
    output logic [2:0] current_comparator,
    output logic external_interrupt_line
);
    timeunit 1ns;
    timeprecision 1ps;

    // outputs start low
    initial
    begin
        current_comparator = 3'h0;
        external_interrupt_line = 1'b0;
    end
    // settling keeps pin edges off clock edges
    always @(over)
        current_comparator <= #(SETTLE_NS) over;
    always @(ext_drive)
        external_interrupt_line <= #(SETTLE_NS) ext_drive;
endmodule

// File: tb/opa_ctrl_assertions.sv
// checker: bus answer, gain decode, temperature code and protection outputs
module opa_ctrl_checker
    import opa_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [2:0] phase_gain_sel,
    input wire opa_gain_kind_t phase_gain_kind,
    input wire logic [1:0] phase_gain_log2,
    input wire logic [2:0] bus_gain_sel,
    input wire opa_gain_kind_t bus_gain_kind,
    input wire logic [1:0] bus_gain_log2,
    input wire logic [3:0] temp_code,
    input wire logic temp_code_valid,
    input wire logic phase_neg_ground_en,
    input wire logic phase_midpoint_reduced,
    input wire logic main_output_enable,
    input wire logic protection_irq
);
    logic drv_wr;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // a taken write to the driver output register, seen in its address phase
    assign drv_wr = hsel && htrans[1] && hready && hwrite && haddr == {14'h0, IDX_DRIVER_OUT, 2'b00};

    sequence rd_taken;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence

    hresp_okay_a:
        assert property (hresp == 1'b0) else $error("response is not OKAY");
    read_wait_a:
        assert property (rd_taken |=> rd_answer) else $error("read answer not after one wait cycle");
    phase_gain_a:
        assert property (phase_gain_sel inside {[3'd1:3'd4]} |-> phase_gain_kind == OPA_GAIN_INTERNAL
            && phase_gain_log2 == phase_gain_sel[1:0] - 2'd1) else $error("phase gain decode wrong");
    phase_ext_a:
        assert property (!(phase_gain_sel inside {[3'd1:3'd5]}) |-> phase_gain_kind == OPA_GAIN_EXTERNAL
            && phase_gain_log2 == 2'd0) else $error("phase external gain decode wrong");
    bus_gain_a:
        assert property (bus_gain_sel inside {[3'd1:3'd4]} |-> bus_gain_kind == OPA_GAIN_INTERNAL
            && bus_gain_log2 == bus_gain_sel[1:0] - 2'd1) else $error("bus gain decode wrong");
    temp_valid_a:
        assert property (temp_code_valid == (temp_code != TEMP_RESERVED)) else $error("temp valid wrong");
    midpoint_sel_a:
        assert property (phase_midpoint_reduced == phase_neg_ground_en) else $error("midpoint select wrong");
    moe_set_sw_a:
        assert property ($rose(main_output_enable) |-> $past(drv_wr, 3) && $past(hwdata[DRV_MOE_BIT], 2))
        else $error("output enable set without a software write");
    irq_clear_sw_a:
        assert property ($fell(protection_irq) |-> $past(drv_wr, 3) && $past(hwdata[DRV_FLAG_BIT], 2))
        else $error("protection flag cleared without a software write");
    shutdown_flag_a:
        assert property ($fell(main_output_enable) && !$past(drv_wr, 3) |-> protection_irq)
        else $error("automatic shutdown without protection flag");

    cover property ($fell(main_output_enable));
endmodule

// File: tb/test_overcurrent_protect_afe_ctrl.sv
// testbench: register access, decode and overcurrent protection scenarios
module test_overcurrent_protect_afe_ctrl;
    import opa_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [2:0] over = 3'h0;
    logic ext_drive = 1'b0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, external_interrupt_line, dac_data_lsb, shared_pin_route_en, temp_code_valid;
    logic [2:0] current_comparator, phase_gain_sel, bus_gain_sel;
    logic bus_amp_enable, phase_a_amp_enable, phase_b_amp_enable, current_comparator_enable;
    logic current_comparator_hyst, current_comparator_out_flag;
    opa_gain_kind_t phase_gain_kind, bus_gain_kind;
    logic [1:0] phase_gain_log2, bus_gain_log2, current_comparator_mode;
    logic phase_neg_ground_en, bus_neg_ground_en, phase_midpoint_reduced, bus_midpoint_reduced;
    logic main_output_enable, protection_irq;
    logic [3:0] temp_code;
    logic [15:0] regs [8] = '{IDX_AMP_ENABLE, IDX_AMP_GAIN, IDX_GROUND_TEMP, IDX_EVENT_FILTER,
        IDX_CMP_CTRL_0, IDX_CMP_CTRL_1, IDX_DRIVER_OUT, 16'h4104};
    int n_errors = 0;
    int tests_run = 0;

    // 40 MHz system clock
    always #12.5 clock = ~clock;

    opa_ctrl dut (.*, .hready(hreadyout));
    opa_analog_model #(.SETTLE_NS(7)) far (.over, .ext_drive, .current_comparator, .external_interrupt_line);

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            $display("BAD %s expected %h seen %h", name, exp, seen);
            n_errors++;
        end
    endtask

    // wait for hready high at an edge; a dead slave counts as a mismatch
    task automatic wait_ready;
        int n = 0;
        @(posedge clock);
        while (hreadyout !== 1'b1 && n < 20)
        begin
            @(posedge clock);
            n++;
        end
        if (n >= 20)
            n_errors++;
    endtask

    // single word transfer; read data taken as the data phase ends
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] data);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {14'h0, idx, 2'b00};
        hwrite <= wr;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= data;
        wait_ready;
        rd = hrdata;
    endtask

    // expected {kind, log2} for a gain code
    function automatic logic [3:0] gk(input logic [2:0] g);
        if (g inside {[3'd1:3'd4]})
            return {2'd1, g[1:0] - 2'd1};
        return (g == GAIN_RESERVED) ? 4'h8 : 4'h0;
    endfunction

    // configure, arm, disturb for len cycles, watch; idle ext level avoids false edges
    task automatic ev(input logic [6:0] evf, input logic [2:0] cc0, input logic [3:0] cc1, input logic [2:0] trip,
        input int len, input logic exp_irq, input logic exp_moe);
        int w = (evf[4:3] == 2'b00) ? 0 : 2 << evf[4:3];
        int first = -1;
        bus(1, IDX_CMP_CTRL_0, {29'h0, cc0});
        ext_drive <= cc0[CC0_EDGE_SEL_BIT];
        bus(1, IDX_CMP_CTRL_1, {29'h0, cc1[2:0]});
        bus(1, IDX_CMP_CTRL_1, {28'h0, cc1});
        bus(1, IDX_EVENT_FILTER, {25'h0, evf});
        repeat (20) @(posedge clock);
        bus(1, IDX_DRIVER_OUT, 32'h3);
        repeat (2) @(posedge clock);
        chk("armed moe", main_output_enable, 1'b1);
        chk("armed irq", protection_irq, 1'b0);
        chk("cmp ctrl", {current_comparator_enable, current_comparator_hyst, current_comparator_mode}, cc1);
        for (int i = 0; i < 60; i++)
        begin
            over <= (i < len) ? trip : 3'h0;
            ext_drive <= cc0[CC0_EDGE_SEL_BIT] ^ (trip == 3'h0 && i < len);
            @(posedge clock);
            if (first < 0 && protection_irq === 1'b1)
                first = i;
            if (i == 10)
                chk("cmp flag", current_comparator_out_flag, cc1[3] && len > 10 && |(trip & {cc1[1], |cc1[1:0], 1'b1}));
        end
        chk("irq after event", protection_irq, exp_irq);
        chk("moe after event", main_output_enable, exp_moe);
        if (exp_irq)
            chk("event latency", first >= w + 3 && first <= w + 8, 1'b1);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        foreach (regs[i])
        begin
            bus(0, regs[i], 32'h0);
            chk("reset value", rd, 32'h0);
        end
        bus(1, IDX_AMP_ENABLE, 32'hffff_fffe);
        bus(0, IDX_AMP_ENABLE, 32'h0);
        chk("amp enable readback", rd, 32'h6);
        chk("amp ports", {bus_amp_enable, phase_a_amp_enable, phase_b_amp_enable}, 3'b011);
        for (logic [3:0] c = 0; c < 8; c++)
        begin
            bus(1, IDX_AMP_GAIN, {24'h0, c[0], c[2:0], ~c[2:0], c[0]});
            bus(0, IDX_AMP_GAIN, 32'h0);
            chk("gain readback", rd, {24'h0, c[0], c[2:0], ~c[2:0], c[0]});
            chk("phase gain", {phase_gain_kind, phase_gain_log2}, gk(c[2:0]));
            chk("bus gain", {bus_gain_kind, bus_gain_log2}, gk(~c[2:0]));
            chk("lsb and route", {dac_data_lsb, shared_pin_route_en}, {2{c[0]}});
        end
        for (logic [4:0] t = 0; t < 16; t++)
        begin
            bus(1, IDX_EVENT_FILTER, {25'h0, t[2:1], 5'h0});
            bus(1, IDX_GROUND_TEMP, {28'h0, t[1], t[2], t[3], t[0]});
            repeat (2) @(posedge clock);
            chk("temp code", temp_code, t[3:0]);
            chk("temp valid", temp_code_valid, t[3:0] != 4'b0111);
            chk("grounds", {phase_neg_ground_en, bus_neg_ground_en}, {t[1], t[2]});
            chk("midpoint", {phase_midpoint_reduced, bus_midpoint_reduced}, {t[1], t[2]});
        end
        ev(7'h09, 3'h3, 4'hc, 3'h1, 30, 1'b1, 1'b0);
        ev(7'h11, 3'h3, 4'hc, 3'h1, 30, 1'b1, 1'b0);
        ev(7'h19, 3'h3, 4'hc, 3'h1, 30, 1'b1, 1'b0);
        ev(7'h09, 3'h3, 4'hc, 3'h1, 3, 1'b0, 1'b1);
        ev(7'h19, 3'h3, 4'hc, 3'h1, 14, 1'b0, 1'b1);
        ev(7'h00, 3'h3, 4'hc, 3'h1, 30, 1'b1, 1'b1);
        ev(7'h09, 3'h1, 4'hc, 3'h1, 30, 1'b0, 1'b1);
        ev(7'h09, 3'h3, 4'hc, 3'h4, 30, 1'b0, 1'b1);
        ev(7'h09, 3'h3, 4'he, 3'h4, 30, 1'b1, 1'b0);
        ev(7'h09, 3'h3, 4'hd, 3'h2, 30, 1'b1, 1'b0);
        ev(7'h09, 3'h3, 4'h4, 3'h1, 30, 1'b0, 1'b1);
        ev(7'h0d, 3'h0, 4'h4, 3'h0, 30, 1'b1, 1'b0);
        ev(7'h0d, 3'h4, 4'h4, 3'h0, 30, 1'b1, 1'b0);
        results;
    end

    // watchdog: about 1400 cycles expected
    initial
    begin
        #(25 * 20000);
        n_errors++;
        results;
    end
endmodule

bind opa_ctrl opa_ctrl_checker prot_chk (.clock, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hreadyout, .hresp, .phase_gain_sel, .phase_gain_kind, .phase_gain_log2, .bus_gain_sel, .bus_gain_kind,
    .bus_gain_log2, .temp_code, .temp_code_valid, .phase_neg_ground_en, .phase_midpoint_reduced,
    .main_output_enable, .protection_irq);
